// ---- shared/swc_pkg.sv ----
// constants shared by both ends of the switch control link
package swc_pkg;

  // ---------------------------------------------------------------
  // frame and channel layout
  // ---------------------------------------------------------------
  localparam int CMD_W    = 16;
  localparam int HS_N     = 4;
  localparam int LS_N     = 8;
  localparam int LS_LO    = 4;
  localparam int CH_N     = 12;
  localparam int OP_HI    = 15;
  localparam int OP_LO    = 12;
  localparam int SNS01_LO = 0;
  localparam int SNS23_LO = 2;

  // ---------------------------------------------------------------
  // command opcodes in bits 15:12
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_OUT = 4'h0;
  localparam logic [3:0] OP_CFG = 4'h1;
  localparam logic [3:0] OP_SNS = 4'h2;

  // ---------------------------------------------------------------
  // current sense source codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SNS_OFF = 2'h0;
  localparam logic [1:0] SNS_A   = 2'h1;
  localparam logic [1:0] SNS_B   = 2'h2;
  localparam logic [1:0] SNS_SUM = 2'h3;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_RST = 16'h0000;
  localparam int CLK_MHZ       = 40;
  localparam int WD_TIMEOUT_US = 10000;
  localparam int WD_CYCLES     = WD_TIMEOUT_US * CLK_MHZ;
  localparam int SCLK_HALF_CYC = 8;

endpackage

// ---- shared/swc_link_if.sv ----
// serial link and device pins between bus master and switch device
`timescale 1ns/1ps
interface swc_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic miso;
  logic rst_n;
  logic watchdog_kick_input;

  // undriven data line reads low
  assign miso = so_oe ? so : 1'b0;

  modport device (
    input  cs_n,
    input  sclk,
    input  si,
    input  rst_n,
    input  watchdog_kick_input,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output si,
    output rst_n,
    output watchdog_kick_input,
    input  miso
  );
endinterface

// ---- rtl/swc_device.sv ----
// switch device end: serial command port, channel control, watchdog
//
// Behaviour
// - data output floats unless chip select low
// - output data changes on serial clock rise
// - fault bits returned msb first when selected
// - twelve fault bits, bit n is channel n
// - master selects by chip select, others float
// - master clocks one cycle per bit, idle between
// - command frame is 16 bits msb first
// - bits 3:0 drive high-side channels 3:0
// - bits 11:4 drive low-side channels 11:4
// - master holds data valid at falling edge
// - daisy chain passes data through to output
// - low-side direct input drives assigned channels only
// - each high-side direct input drives one channel
// - high-side source is command or direct input
// - sense source selectable as either channel
// - sense also offers sum of both channels
// - fail-safe forces high-side channel 2 on
// - fail-safe forces high-side channel 0 on
// - watchdog runs only while wake is high
// - reset low clears state, release starts watchdog
// - no watchdog toggle in window enters fail-safe
// - fail-safe select low disables watchdog entirely
// - fault status low while any fault held
`timescale 1ns/1ps
module swc_device
  import swc_pkg::*;
#(
  parameter int WD_LIMIT = swc_pkg::WD_CYCLES
)(
  // clock, reset, enable
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                ce_i,
  // link
  swc_link_if.device               link,
  // direct inputs and straps
  input  wire logic [swc_pkg::HS_N-1:0] hs_direct_i,
  input  wire logic                low_side_direct_i,
  input  wire logic                wake_i,
  input  wire logic                fail_safe_select_i,
  // channel fault detectors
  input  wire logic [swc_pkg::CH_N-1:0] fault_i,
  // channel controls and status
  output logic [swc_pkg::HS_N-1:0] high_side_channel_o,
  output logic [swc_pkg::LS_N-1:0] low_side_channel_o,
  output logic [1:0]               sense01_sel_o,
  output logic [1:0]               sense23_sel_o,
  output logic                     fail_safe_o,
  output logic                     fault_status_n_o
);
  import swc_pkg::*;

  localparam int SY_W = 12;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SY_W-1:0] sy1_reg, sy2_reg, sy3_reg;
  logic [SY_W-1:0] sy_pins;

  assign sy_pins = {link.cs_n, link.sclk, link.si, link.rst_n,
                    link.watchdog_kick_input, wake_i, fail_safe_select_i,
                    low_side_direct_i, hs_direct_i};

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      {sy1_reg, sy2_reg, sy3_reg} <= '1;
    end
    else if (ce_i)
    begin
      {sy3_reg, sy2_reg, sy1_reg} <= {sy2_reg, sy1_reg, sy_pins};
    end
  end

  logic            cs_s, sclk_s, si_s, rstn_s, watchdog_kick_input_s, wake_s, fsi_s, ils_s;
  logic [HS_N-1:0] ihs_s;
  logic            cs_d_reg, sclk_d_reg, rstn_d_reg, watchdog_kick_input_d_reg;

  assign {cs_s, sclk_s, si_s, rstn_s, watchdog_kick_input_s, wake_s, fsi_s,
          ils_s, ihs_s} = sy2_reg;
  assign {cs_d_reg, sclk_d_reg} = sy3_reg[SY_W-1:SY_W-2];
  assign {rstn_d_reg, watchdog_kick_input_d_reg} = sy3_reg[SY_W-4:SY_W-5];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CMD_W-1:0] sr_reg,      sr_next;
  logic [3:0]       bit_cnt_reg, bit_cnt_next;
  logic             full_reg,    full_next;
  logic             so_reg,      so_next;
  logic [CMD_W-1:0] cmd_reg,     cmd_next;
  logic [HS_N-1:0]  hs_en_reg,   hs_en_next;
  logic [LS_N-1:0]  ls_en_reg,   ls_en_next;
  logic [1:0]       s01_reg,     s01_next;
  logic [1:0]       s23_reg,     s23_next;
  logic [CH_N-1:0]  fault_reg,   fault_next;
  logic [31:0]      wd_cnt_reg,  wd_cnt_next;
  logic             fs_reg,      fs_next;
  logic [HS_N-1:0]  hs_reg,      hs_next;
  logic [LS_N-1:0]  ls_reg,      ls_next;

  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic frame_ok, standby, wd_on;

  always_comb
  begin
    sclk_rise   = sclk_s & ~sclk_d_reg;
    sclk_fall   = ~sclk_s & sclk_d_reg;
    cs_fall     = ~cs_s & cs_d_reg;
    cs_rise     = cs_s & ~cs_d_reg;
    standby     = ~rstn_s;

    // -------------------------------------------------------------
    // serial shifter
    // -------------------------------------------------------------
    sr_next      = sr_reg;
    bit_cnt_next = bit_cnt_reg;
    full_next    = full_reg;
    so_next      = so_reg;
    if (cs_fall)
    begin
      sr_next      = {{(CMD_W-CH_N){1'b0}}, fault_reg};
      bit_cnt_next = 4'h0;
      full_next    = 1'b0;
      so_next      = 1'b0;
    end
    else if (!cs_s)
    begin
      if (sclk_rise)
      begin
        so_next = sr_reg[CMD_W-1];
        sr_next = {sr_reg[CMD_W-2:0], 1'b0};
      end
      if (sclk_fall)
      begin
        sr_next[0]   = si_s;
        bit_cnt_next = bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == 4'hf)
          full_next = 1'b1;
      end
    end
    // whole multiples of 16 bits only; longer frames keep last word
    frame_ok = cs_rise & full_reg & (bit_cnt_reg == 4'h0);

    // -------------------------------------------------------------
    // command and configuration
    // -------------------------------------------------------------
    cmd_next   = cmd_reg;
    hs_en_next = hs_en_reg;
    ls_en_next = ls_en_reg;
    s01_next   = s01_reg;
    s23_next   = s23_reg;
    if (standby)
    begin
      cmd_next   = CMD_RST;
      hs_en_next = '0;
      ls_en_next = '0;
      s01_next   = SNS_OFF;
      s23_next   = SNS_OFF;
    end
    else if (frame_ok)
    begin
      case (sr_reg[OP_HI:OP_LO])
        OP_OUT:
          cmd_next = sr_reg;
        OP_CFG:
        begin
          hs_en_next = sr_reg[HS_N-1:0];
          ls_en_next = sr_reg[LS_LO+LS_N-1:LS_LO];
        end
        OP_SNS:
        begin
          s01_next = sr_reg[SNS01_LO+1:SNS01_LO];
          s23_next = sr_reg[SNS23_LO+1:SNS23_LO];
        end
        default: ;
      endcase
    end
    // fault capture, a fault in the frame-end cycle stays set
    fault_next = standby ? '0 : frame_ok ? fault_i : fault_reg | fault_i;

    // -------------------------------------------------------------
    // watchdog
    // -------------------------------------------------------------
    wd_on       = wake_s & fsi_s & ~standby;
    wd_cnt_next = wd_cnt_reg;
    fs_next     = fs_reg;
    if (standby || !fsi_s)
      fs_next = 1'b0;
    if (!wd_on || fs_reg)
      wd_cnt_next = 32'h0;
    else if ((rstn_s & ~rstn_d_reg) || (watchdog_kick_input_s ^ watchdog_kick_input_d_reg))
      wd_cnt_next = 32'h0;
    else if (wd_cnt_reg >= 32'(WD_LIMIT - 1))
    begin
      wd_cnt_next = 32'h0;
      fs_next     = 1'b1;
    end
    else
      wd_cnt_next = wd_cnt_reg + 32'h1;
    // channel drive
    for (int i = 0; i < HS_N; i++)
      hs_next[i] = hs_en_reg[i] ? ihs_s[i] : cmd_reg[i];
    for (int j = 0; j < LS_N; j++)
      ls_next[j] = ls_en_reg[j] ? ils_s : cmd_reg[LS_LO+j];
    hs_next[2] = hs_next[2] | fs_reg;
    hs_next[0] = hs_next[0] | fs_reg;
    if (standby)
      {hs_next, ls_next} = '0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sr_reg      <= CMD_RST;
      bit_cnt_reg <= 4'h0;
      full_reg    <= 1'b0;
      so_reg      <= 1'b0;
      cmd_reg     <= CMD_RST;
      hs_en_reg   <= '0;
      ls_en_reg   <= '0;
      s01_reg     <= SNS_OFF;
      s23_reg     <= SNS_OFF;
      fault_reg   <= '0;
      wd_cnt_reg  <= 32'h0;
      fs_reg      <= 1'b0;
      hs_reg      <= '0;
      ls_reg      <= '0;
    end
    else if (ce_i)
    begin
      sr_reg      <= sr_next;
      bit_cnt_reg <= bit_cnt_next;
      full_reg    <= full_next;
      so_reg      <= so_next;
      cmd_reg     <= cmd_next;
      hs_en_reg   <= hs_en_next;
      ls_en_reg   <= ls_en_next;
      s01_reg     <= s01_next;
      s23_reg     <= s23_next;
      fault_reg   <= fault_next;
      wd_cnt_reg  <= wd_cnt_next;
      fs_reg      <= fs_next;
      hs_reg      <= hs_next;
      ls_reg      <= ls_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.so             = so_reg;
  assign link.so_oe          = ~cs_s & ~cs_d_reg;
  assign high_side_channel_o = hs_reg;
  assign low_side_channel_o  = ls_reg;
  assign sense01_sel_o       = s01_reg;
  assign sense23_sel_o       = s23_reg;
  assign fail_safe_o         = fs_reg;
  assign fault_status_n_o    = ~(|fault_reg);

endmodule

// ---- rtl/swc_host.sv ----
// bus master end: frames 16-bit commands, returns the word shifted back
`timescale 1ns/1ps
module swc_host
  import swc_pkg::*;
#(
  parameter int HALF = swc_pkg::SCLK_HALF_CYC
)(
  // clock, reset, enable
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  // command port
  input  wire logic                    cmd_valid_i,
  input  wire logic [swc_pkg::CMD_W-1:0] cmd_data_i,
  output logic                         cmd_ready_o,
  output logic                         resp_valid_o,
  output logic [swc_pkg::CMD_W-1:0]    resp_data_o,
  // device control
  input  wire logic                    dev_reset_i,
  input  wire logic                    wd_kick_i,
  // link
  swc_link_if.host                     link
);
  import swc_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LEAD = 5'b00010,
    H_HIGH = 5'b00100,
    H_LOW  = 5'b01000,
    H_TAIL = 5'b10000
  } swc_hst_e;

  // ---------------------------------------------------------------
  // miso synchroniser
  // ---------------------------------------------------------------
  logic miso1_reg;
  logic miso2_reg;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      miso1_reg <= 1'b0;
      miso2_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      miso1_reg <= link.miso;
      miso2_reg <= miso1_reg;
    end
  end

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  swc_hst_e         st_reg,   st_next;
  logic [7:0]       div_reg,  div_next;
  logic [4:0]       nb_reg,   nb_next;
  logic [CMD_W-1:0] tx_reg,   tx_next;
  logic [CMD_W-1:0] rx_reg,   rx_next;
  logic             cs_reg,   cs_next;
  logic             sclk_reg, sclk_next;
  logic             si_reg,   si_next;
  logic             rv_reg,   rv_next;
  logic             wd_reg,   wd_next;
  logic             tick;

  always_comb
  begin
    st_next   = st_reg;
    div_next  = div_reg + 8'h1;
    nb_next   = nb_reg;
    tx_next   = tx_reg;
    rx_next   = rx_reg;
    cs_next   = cs_reg;
    sclk_next = sclk_reg;
    si_next   = si_reg;
    rv_next   = 1'b0;
    wd_next   = wd_reg ^ wd_kick_i;
    tick      = (div_reg == 8'(HALF - 1));
    if (tick)
      div_next = 8'h0;
    case (st_reg)
      H_IDLE:
      begin
        div_next = 8'h0;
        if (cmd_valid_i)
        begin
          tx_next = cmd_data_i;
          nb_next = 5'h0;
          cs_next = 1'b0;
          st_next = H_LEAD;
        end
      end
      H_LEAD, H_LOW:
        if (tick)
        begin
          if (nb_reg == 5'(CMD_W))
            st_next = H_TAIL;
          else
          begin
            sclk_next = 1'b1;
            si_next   = tx_reg[CMD_W-1];
            tx_next   = {tx_reg[CMD_W-2:0], 1'b0};
            st_next   = H_HIGH;
          end
        end
      H_HIGH:
        if (tick)
        begin
          sclk_next = 1'b0;
          rx_next   = {rx_reg[CMD_W-2:0], miso2_reg};
          nb_next   = nb_reg + 5'h1;
          st_next   = H_LOW;
        end
      H_TAIL:
        if (tick)
        begin
          if (cs_reg)
            st_next = H_IDLE;
          else
          begin
            cs_next = 1'b1;
            rv_next = 1'b1;
          end
        end
      default:
        st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_reg   <= H_IDLE;
      div_reg  <= 8'h0;
      nb_reg   <= 5'h0;
      tx_reg   <= CMD_RST;
      rx_reg   <= CMD_RST;
      cs_reg   <= 1'b1;
      sclk_reg <= 1'b0;
      si_reg   <= 1'b0;
      rv_reg   <= 1'b0;
      wd_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      nb_reg   <= nb_next;
      tx_reg   <= tx_next;
      rx_reg   <= rx_next;
      cs_reg   <= cs_next;
      sclk_reg <= sclk_next;
      si_reg   <= si_next;
      rv_reg   <= rv_next;
      wd_reg   <= wd_next;
    end
  end

  assign cmd_ready_o  = (st_reg == H_IDLE);
  assign resp_valid_o = rv_reg;
  assign resp_data_o  = rx_reg;
  assign link.cs_n    = cs_reg;
  assign link.sclk    = sclk_reg;
  assign link.si      = si_reg;
  assign link.rst_n   = ~dev_reset_i;
  assign link.watchdog_kick_input    = wd_reg;

endmodule

// ---- test/swc_link_sva.sv ----
// link protocol assertions for the switch control serial link
`timescale 1ns/1ps
module swc_link_sva (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic miso,
  input wire logic rst_n,
  input wire logic watchdog_kick_input
);
  // ---------------------------------------------------------------
  // serial clock rises seen in the current frame
  // ---------------------------------------------------------------
  logic [5:0] bits_reg;
  logic [5:0] bits_next;
  logic       sclk_reg;
  logic       sclk_next;

  always_comb
  begin
    sclk_next = sclk;
    bits_next = bits_reg;
    if (cs_n)
      bits_next = 6'h00;
    else if (sclk && !sclk_reg)
      bits_next = bits_reg + 6'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      bits_reg <= 6'h00;
      sclk_reg <= 1'b0;
    end
    else
    begin
      bits_reg <= bits_next;
      sclk_reg <= sclk_next;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_oe_off_unsel: assert property (cs_n [*4] |-> !so_oe)
    else $error("data output driven while unselected");
  a_miso_floats: assert property (!so_oe |-> !miso)
    else $error("data line not released");
  a_oe_on_sel: assert property (!cs_n [*4] |-> so_oe)
    else $error("data output not driven while selected");
  a_so_on_rise: assert property (!cs_n && so_oe && $past(so_oe)
    && $changed(so) |-> sclk && $past(sclk, 2))
    else $error("data output changed away from clock rise");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock not idle between frames");
  a_sclk_high_len: assert property ($rose(sclk)
    |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase wrong length");
  a_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  a_sclk_after_sel: assert property ($rose(sclk)
    |-> !cs_n && !$past(cs_n, 3))
    else $error("serial clock before device selected");
  a_frame_bits: assert property ($rose(cs_n) |-> bits_reg == 6'h10)
    else $error("frame not sixteen clocks long");
  a_si_at_rise: assert property (!cs_n && $past(!cs_n)
    && $changed(si) && bits_reg != 6'h10 |-> $rose(sclk))
    else $error("serial input changed off clock rise");
  a_si_hold_fall: assert property ($fell(sclk) |-> $stable(si))
    else $error("serial input changed at falling edge");

  cover property ($rose(cs_n) && bits_reg == 6'h10);
  cover property ($rose(so_oe));
  cover property ($changed(watchdog_kick_input));
  cover property ($rose(rst_n));
endmodule

// ---- test/test_spi_output_switch_control.sv ----
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module test_spi_output_switch_control;
  import swc_pkg::*;

  // ---------------------------------------------------------------
  // stimulus, observed outputs and expected state
  // ---------------------------------------------------------------
  localparam int WD_SIM = 200;
  logic        mclk_i     = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        cmd_valid  = 1'b0;
  logic [15:0] cmd_data   = 16'h0000;
  logic        dev_reset  = 1'b0;
  logic        wd_kick    = 1'b0;
  logic [3:0]  hs_dir     = 4'h0;
  logic        ls_dir     = 1'b0;
  logic        wake       = 1'b0;
  logic        fail_safe_select        = 1'b1;
  logic [11:0] fault      = 12'h000;
  logic        cmd_ready;
  logic        resp_valid;
  logic [15:0] resp_data;
  logic [3:0]  hs_o;
  logic [7:0]  ls_o;
  logic [1:0]  s01;
  logic [1:0]  s23;
  logic        fs_o;
  logic        fsn_o;
  logic [11:0] sticky     = 12'h000;
  logic [11:0] out_cmd    = 12'h000;
  logic [3:0]  en_hs      = 4'h0;
  logic [7:0]  as_ls      = 8'h00;
  logic [3:0]  sns        = 4'h0;
  logic        fs_exp     = 1'b0;
  logic [4:0]  lfsr_q     = 5'h1e;
  logic [17:0] e;
  logic [15:0] exp_q[$];
  int          n_fail     = 0;
  int          num_checks = 0;

  swc_link_if link ();

  swc_host i_swc_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .cmd_valid_i(cmd_valid), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
    .resp_valid_o(resp_valid), .resp_data_o(resp_data),
    .dev_reset_i(dev_reset), .wd_kick_i(wd_kick), .link(link));

  swc_device #(.WD_LIMIT(WD_SIM)) i_swc_device (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .ce_i(1'b1), .link(link), .hs_direct_i(hs_dir),
    .low_side_direct_i(ls_dir), .wake_i(wake), .fail_safe_select_i(fail_safe_select),
    .fault_i(fault), .high_side_channel_o(hs_o), .low_side_channel_o(ls_o),
    .sense01_sel_o(s01), .sense23_sel_o(s23), .fail_safe_o(fs_o),
    .fault_status_n_o(fsn_o));

  swc_link_sva i_swc_link_sva (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so),
    .so_oe(link.so_oe), .miso(link.miso), .rst_n(link.rst_n),
    .watchdog_kick_input(link.watchdog_kick_input));

  initial
  begin
    forever
      #12.5 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] rnd();
    logic [15:0] v;
    v = 16'h0000;
    for (int k = 0; k < 16; k++)
    begin
      lfsr_q = {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
      v = {v[14:0], lfsr_q[0]};
    end
    return v;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [3:0] op, input logic [11:0] d);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100)
    begin
      @(posedge mclk_i);
      k++;
    end
    exp_q.push_back({4'h0, sticky});
    cmd_data  <= {op, d};
    cmd_valid <= 1'b1;
    @(posedge mclk_i);
    cmd_valid <= 1'b0;
    while (resp_valid !== 1'b1 && k < 500)
    begin
      @(posedge mclk_i);
      k++;
    end
    if (k >= 500)
    begin
      n_fail++;
      stop_test();
    end
    cyc(12);
    sticky = fault;
    case (op)
      OP_OUT: out_cmd = d;
      OP_CFG:
      begin
        en_hs = d[3:0];
        as_ls = d[11:4];
      end
      OP_SNS: sns = d[3:0];
      default: ;
    endcase
  endtask

  task automatic chk_out();
    logic [3:0] h;
    logic [7:0] l;
    h = (out_cmd[3:0] & ~en_hs) | (hs_dir & en_hs);
    l = (out_cmd[11:4] & ~as_ls) | ({8{ls_dir}} & as_ls);
    if (fs_exp)
      h = h | 4'h5;
    check({fs_o, fsn_o, s23, s01, ls_o, hs_o}, {fs_exp, ~|sticky, sns, l, h});
  endtask

  // ---------------------------------------------------------------
  // returned words
  // ---------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    if (resp_valid === 1'b1)
    begin
      e = (exp_q.size() > 0) ? {2'b00, exp_q.pop_front()} : 'x;
      check({2'b00, resp_data}, e);
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    cyc(12);
    sys_rst_i <= 1'b0;
    cyc(3);
    chk_out();
    for (int i = 0; i < 6; i++)
    begin
      v = rnd();
      fault  <= v[11:0];
      hs_dir <= v[15:12];
      sticky = sticky | v[11:0];
      cyc(2);
      v = rnd();
      send(OP_OUT, v[11:0]);
      chk_out();
    end
    for (int k = 0; k < 4; k++)
    begin
      send(OP_SNS, {8'h00, 2'(3 - k), 2'(k)});
      chk_out();
    end
    send(4'h7, 12'hfff);
    chk_out();
    v = rnd();
    send(OP_CFG, v[11:0]);
    v = rnd();
    send(OP_OUT, v[11:0]);
    for (int b = 0; b < 2; b++)
    begin
      v = rnd();
      ls_dir <= b[0];
      hs_dir <= v[3:0];
      cyc(6);
      chk_out();
    end
    cyc(300);
    chk_out();
    wake <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      cyc(100);
      wd_kick <= 1'b1;
      cyc(1);
      wd_kick <= 1'b0;
      chk_out();
    end
    cyc(260);
    fs_exp = 1'b1;
    chk_out();
    fail_safe_select <= 1'b0;
    cyc(6);
    fs_exp = 1'b0;
    chk_out();
    fault     <= 12'h000;
    fail_safe_select       <= 1'b1;
    dev_reset <= 1'b1;
    {sticky, out_cmd, en_hs, as_ls, sns} = '0;
    cyc(8);
    chk_out();
    dev_reset <= 1'b0;
    cyc(150);
    chk_out();
    cyc(110);
    fs_exp = 1'b1;
    chk_out();
    stop_test();
  end
endmodule
